// *** logic/regulator_serial_slave_status.sv ***
// Regulator two-wire slave with status flags and on/off mode control
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

// Functional notes
// - Input overvoltage stops switching, auto resume
// - Input overvoltage sets sticky power fault flag
// - Status read clears fault only when cause gone
// - Thermal off above 150C, on below 130C
// - Serial port works during thermal shutdown
// - Overtemperature sets sticky overtemp flag
// - Status read clears overtemp only below 130C
// - Power good above 95%, fault below 90%
// - Power fault sets flag, read clears when good
// - Enable low: discharge on, load path open
// - On mode needs supply above lockout and enable
// - Slave only, rate independent of bit rate
// - Only 7-bit address, no general call
// - Answers fixed address 1110101b
// - Master sends STOP after bus power up
// - START is SDA fall while SCL high
// - SDA stable while SCL high
// - Ack low through ninth clock on match only
// - Byte is eight bits plus acknowledge
// - STOP releases bus, wait for new START
// - Unmapped register reads return 00h
// - Write commits on falling edge of ack
module regulator_serial_slave_status #(
   parameter regulator_pkg::byte_t IDENTITY = 8'h5A   // Arbitrary value
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   two_wire_if.slave                 bus,
   input  wire logic                 i_en,
   input  wire logic                 i_supply_ok,
   input  wire logic                 i_vin_over,
   input  wire logic                 i_temp_hot,
   input  wire logic                 i_temp_cool,
   input  wire logic                 i_out_above_good,
   input  wire logic                 i_out_below_fault,
   output logic                      o_mode_on,
   output logic                      o_switch_en,
   output logic                      o_discharge,
   output logic                      o_load_connect,
   output regulator_pkg::byte_t      o_control,
   output logic [6:0]                o_level_primary,
   output logic [6:0]                o_level_secondary
);
   import regulator_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TX_ACK} slave_state_e;
   typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} byte_phase_e;

   // ===========================================================
   // Input synchronisers
   localparam int NSYNC = 9;
   localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h003;   // Lines idle high; no false event after reset
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [1:0]       line_d_ff;

   assign raw_in = {i_out_below_fault, i_out_above_good, i_temp_cool, i_temp_hot,
                    i_vin_over, i_supply_ok, i_en, bus.sda, bus.scl};

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync1_ff  <= SYNC_IDLE;
         sync2_ff  <= SYNC_IDLE;
         line_d_ff <= 2'h3;
      end
      else
      begin
         sync1_ff  <= raw_in;
         sync2_ff  <= sync1_ff;
         line_d_ff <= sync2_ff[1:0];
      end
   end

   wire scl_s     = sync2_ff[0];
   wire sda_s     = sync2_ff[1];
   wire en_s      = sync2_ff[2];
   wire supply_s  = sync2_ff[3];
   wire vin_over  = sync2_ff[4];
   wire hot_s     = sync2_ff[5];
   wire cool_s    = sync2_ff[6];
   wire above_s   = sync2_ff[7];
   wire below_s   = sync2_ff[8];
   wire scl_d     = line_d_ff[0];
   wire sda_d     = line_d_ff[1];
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // ===========================================================
   // Serial engine state
   slave_state_e state_ff, nxt_state;
   byte_phase_e  phase_ff, nxt_phase;
   logic [3:0]   cnt_ff, nxt_cnt;
   byte_t        shift_ff, nxt_shift;
   byte_t        ptr_ff, nxt_ptr;
   logic         drive_ff, nxt_drive;
   logic         rw_ff, nxt_rw;
   logic         nack_ff, nxt_nack;
   byte_t        control_ff;
   logic [6:0]   level1_ff;
   logic [6:0]   level2_ff;
   logic         pgood_ff;
   logic         fault_ff;
   logic         ot_active_ff;
   logic         ot_flag_ff;

   // Only the exact 7-bit address matches; 10-bit prefixes and general call never do
   wire   addr_hit = (shift_ff[7:1] == DEV_ADDR);
   byte_t status_byte;
   byte_t rd_byte;
   assign status_byte = {6'h00, ot_flag_ff, fault_ff};
   assign rd_byte = (ptr_ff == OFS_CONTROL)  ? control_ff :
                    (ptr_ff == OFS_STATUS)   ? status_byte :
                    (ptr_ff == OFS_IDENTITY) ? IDENTITY :
                    (ptr_ff == OFS_LEVEL1)   ? {1'b0, level1_ff} :
                    (ptr_ff == OFS_LEVEL2)   ? {1'b0, level2_ff} :
                    READ_UNMAPPED;

   wire bus_cond = start_det | stop_det;
   // Byte is fetched for sending after an address ack with read direction, or after a master ack
   wire load_tx = scl_fall & ~bus_cond &
                  (((state_ff == ST_ACK) & (phase_ff == PH_ADDR) & rw_ff) |
                   ((state_ff == ST_TX_ACK) & ~nack_ff));
   wire wr_commit = scl_fall & ~bus_cond & (state_ff == ST_ACK) & (phase_ff == PH_DATA);
   wire stat_rd   = load_tx & (ptr_ff == OFS_STATUS);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_cnt   = cnt_ff;
      nxt_shift = shift_ff;
      nxt_ptr   = ptr_ff;
      nxt_drive = drive_ff;
      nxt_rw    = rw_ff;
      nxt_nack  = nack_ff;
      if (stop_det)
      begin
         nxt_state = ST_IDLE;
         nxt_drive = 1'b0;
      end
      else if (start_det)
      begin
         nxt_state = ST_RX;
         nxt_phase = PH_ADDR;
         nxt_cnt   = 4'h0;
         nxt_drive = 1'b0;
      end
      else if (load_tx)
      begin
         nxt_shift = rd_byte;
         nxt_drive = ~rd_byte[7];
         nxt_cnt   = 4'h0;
         nxt_ptr   = ptr_ff + 8'h01;
         nxt_state = ST_TX;
      end
      else
      begin
         unique case (state_ff)
            ST_IDLE: ;
            ST_RX:
               // Sample on rising SCL only; SDA is steady while SCL is high
               if (scl_rise)
               begin
                  nxt_shift = {shift_ff[6:0], sda_s};
                  nxt_cnt   = cnt_ff + 4'h1;
               end
               else if (scl_fall && cnt_ff == 4'h8)
               begin
                  nxt_cnt = 4'h0;
                  if (phase_ff != PH_ADDR || addr_hit)
                  begin
                     nxt_state = ST_ACK;
                     nxt_drive = 1'b1;
                     if (phase_ff == PH_ADDR)
                        nxt_rw = shift_ff[0];
                     if (phase_ff == PH_PTR)
                        nxt_ptr = shift_ff;
                  end
                  else
                     nxt_state = ST_IDLE;
               end
            ST_ACK:
               if (scl_fall)
               begin
                  nxt_drive = 1'b0;
                  nxt_state = ST_RX;
                  nxt_phase = (phase_ff == PH_ADDR) ? PH_PTR : PH_DATA;
                  if (phase_ff == PH_DATA)
                     nxt_ptr = ptr_ff + 8'h01;
               end
            ST_TX:
               if (scl_fall)
               begin
                  if (cnt_ff == 4'h7)
                  begin
                     nxt_drive = 1'b0;
                     nxt_state = ST_TX_ACK;
                  end
                  else
                  begin
                     nxt_shift = {shift_ff[6:0], 1'b0};
                     nxt_drive = ~shift_ff[6];
                     nxt_cnt   = cnt_ff + 4'h1;
                  end
               end
            ST_TX_ACK:
               if (scl_rise)
                  nxt_nack = sda_s;
               else if (scl_fall)
                  nxt_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_ff <= ST_IDLE;
         phase_ff <= PH_ADDR;
         cnt_ff   <= 4'h0;
         shift_ff <= 8'h00;
         ptr_ff   <= 8'h00;
         drive_ff <= 1'b0;
         rw_ff    <= 1'b0;
         nack_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         cnt_ff   <= nxt_cnt;
         shift_ff <= nxt_shift;
         ptr_ff   <= nxt_ptr;
         drive_ff <= nxt_drive;
         rw_ff    <= nxt_rw;
         nack_ff  <= nxt_nack;
      end
   end

   // Slave never drives SDA high, only releases it
   assign bus.s_sda_o  = 1'b0;
   assign bus.s_sda_oe = drive_ff;

   // ===========================================================
   // Register file and status flags; independent of converter state
   wire wr_control = wr_commit & (ptr_ff == OFS_CONTROL);
   wire wr_level1  = wr_commit & (ptr_ff == OFS_LEVEL1);
   wire wr_level2  = wr_commit & (ptr_ff == OFS_LEVEL2);

   wire nxt_pgood   = above_s ? 1'b1 : (below_s ? 1'b0 : pgood_ff);
   wire fault_cond  = ~pgood_ff | vin_over;
   // A new event beats a clear in the same cycle
   wire nxt_fault   = fault_cond | (fault_ff & ~(stat_rd & ~fault_cond));
   wire nxt_ot_act  = hot_s ? 1'b1 : (cool_s ? 1'b0 : ot_active_ff);
   wire nxt_ot_flag = hot_s | (ot_flag_ff & ~(stat_rd & cool_s));

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         control_ff   <= RST_CONTROL;
         level1_ff    <= RST_LEVEL1;
         level2_ff    <= RST_LEVEL2;
         pgood_ff     <= 1'b0;
         fault_ff     <= 1'b0;
         ot_active_ff <= 1'b0;
         ot_flag_ff   <= 1'b0;
      end
      else
      begin
         if (wr_control)
            control_ff <= shift_ff;
         if (wr_level1)
            level1_ff <= shift_ff[6:0];
         if (wr_level2)
            level2_ff <= shift_ff[6:0];
         pgood_ff     <= nxt_pgood;
         fault_ff     <= nxt_fault;
         ot_active_ff <= nxt_ot_act;
         ot_flag_ff   <= nxt_ot_flag;
      end
   end

   // ===========================================================
   // Mode controller and power stage controls
   wire mode_on = supply_s & en_s;
   wire switch  = mode_on & control_ff[CTRL_ENABLE_BIT] & ~vin_over & ~ot_active_ff;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_mode_on         <= 1'b0;
         o_switch_en       <= 1'b0;
         o_discharge       <= 1'b0;
         o_load_connect    <= 1'b0;
         o_control         <= RST_CONTROL;
         o_level_primary   <= RST_LEVEL1;
         o_level_secondary <= RST_LEVEL2;
      end
      else
      begin
         o_mode_on         <= mode_on;
         o_switch_en       <= switch;
         o_discharge       <= ~en_s;
         o_load_connect    <= mode_on;
         o_control         <= control_ff;
         o_level_primary   <= level1_ff;
         o_level_secondary <= level2_ff;
      end
   end
endmodule // regulator_serial_slave_status

// *** common/regulator_pkg.sv ***
// Shared constants for the regulator two-wire slave and its bus master
package regulator_pkg;
   typedef logic [7:0] byte_t;

   // ===========================================================
   // Bus addressing and register map
   localparam logic [6:0] DEV_ADDR      = 7'h75;
   localparam byte_t      OFS_CONTROL   = 8'h01;
   localparam byte_t      OFS_STATUS    = 8'h02;
   localparam byte_t      OFS_IDENTITY  = 8'h03;
   localparam byte_t      OFS_LEVEL1    = 8'h04;
   localparam byte_t      OFS_LEVEL2    = 8'h05;
   localparam byte_t      READ_UNMAPPED = 8'h00;

   // ===========================================================
   // Reset values and field positions
   localparam byte_t      RST_CONTROL   = 8'h20;
   localparam logic [6:0] RST_LEVEL1    = 7'h3C;
   localparam logic [6:0] RST_LEVEL2    = 7'h42;
   localparam int         CTRL_ENABLE_BIT   = 5;
   localparam int         STAT_FAULT_BIT    = 0;
   localparam int         STAT_OVERTEMP_BIT = 1;

   // ===========================================================
   // Timing: 250 MHz core clock, bit periods of the three rates
   localparam int CLK_PERIOD_NS    = 4;
   localparam int BIT_NS_STANDARD  = 10000;
   localparam int BIT_NS_FAST      = 2500;
   localparam int BIT_NS_FAST_PLUS = 1000;
   localparam int QTR_CYC_STANDARD = BIT_NS_STANDARD / (4 * CLK_PERIOD_NS);
   localparam int QTR_CYC_MIN      = 8;

   // ===========================================================
   // Bus master command port map
   localparam logic [2:0] HREG_TARGET = 3'h0;
   localparam logic [2:0] HREG_WDATA  = 3'h1;
   localparam logic [2:0] HREG_CMD    = 3'h2;
   localparam logic [2:0] HREG_STATUS = 3'h3;
   localparam logic [2:0] HREG_RDATA  = 3'h4;
   localparam int         CMD_GO_BIT   = 0;
   localparam int         CMD_READ_BIT = 1;
endpackage

// *** common/two_wire_if.sv ***
// Two-wire open-drain bus joining the master and the regulator slave
`timescale 1ns/10ps
interface two_wire_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // Pull-ups win unless some driver pulls low
   assign scl = ~(m_scl_oe & ~m_scl_o);
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
   modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// *** logic/two_wire_master.sv ***
// Two-wire bus master that performs single register writes and reads
`timescale 1ns/10ps
module two_wire_master #(
   parameter int QTR_CYC = regulator_pkg::QTR_CYC_STANDARD
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   two_wire_if.master                bus,
   input  wire logic [2:0]           i_addr,
   input  wire regulator_pkg::byte_t i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output regulator_pkg::byte_t      o_rdata
);
   import regulator_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} master_state_e;

   if (QTR_CYC < QTR_CYC_MIN || QTR_CYC > 4096)
      $error("QTR_CYC out of range");

   // ===========================================================
   // Command registers
   master_state_e state_ff;
   byte_t         target_ff;
   byte_t         wdat_ff;
   byte_t         rdat_ff;
   logic          is_read_ff;
   logic          cmd_ff;
   logic          nack_flag_ff;
   logic          done_ff;
   logic [11:0]   qcnt_ff;
   logic [1:0]    q_ff;
   logic [3:0]    bit_ff;
   logic [1:0]    idx_ff;
   logic [8:0]    tx_ff;
   logic [8:0]    rx_ff;
   logic          scl_hi_ff;
   logic          sda_hi_ff;
   logic          sda1_ff;
   logic          sda2_ff;

   wire busy    = (state_ff != H_IDLE);
   wire go      = i_wr & (i_addr == HREG_CMD) & i_wdata[CMD_GO_BIT] & ~busy;
   wire stat_rd = i_rd & (i_addr == HREG_STATUS);
   wire tick    = busy & (qcnt_ff == 12'(QTR_CYC - 1));

   byte_t next_byte;
   assign next_byte = (idx_ff == 2'h0) ? {DEV_ADDR, 1'b0} :
                      (idx_ff == 2'h1) ? target_ff :
                      (idx_ff == 2'h2) ? (is_read_ff ? {DEV_ADDR, 1'b1} : wdat_ff) :
                      8'hFF;
   wire last_byte = is_read_ff ? (idx_ff == 2'h3) : (idx_ff == 2'h2);
   // Byte after the current one; a read keeps SDA released so the slave's bits are not masked
   byte_t next_byte_after;
   assign next_byte_after = (idx_ff == 2'h0) ? target_ff : (is_read_ff ? 8'hFF : wdat_ff);
   wire slave_nak = rx_ff[0] & ~(is_read_ff & idx_ff == 2'h3);

   byte_t rd_mux;
   assign rd_mux = (i_addr == HREG_TARGET) ? target_ff :
                   (i_addr == HREG_WDATA)  ? wdat_ff :
                   (i_addr == HREG_STATUS) ? {5'h00, done_ff, nack_flag_ff, busy} :
                   (i_addr == HREG_RDATA)  ? rdat_ff :
                   8'h00;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         target_ff  <= 8'h00;
         wdat_ff    <= 8'h00;
         is_read_ff <= 1'b0;
         o_rdata    <= 8'h00;
         sda1_ff    <= 1'b1;
         sda2_ff    <= 1'b1;
         qcnt_ff    <= 12'h000;
      end
      else
      begin
         if (i_wr && i_addr == HREG_TARGET)
            target_ff <= i_wdata;
         if (i_wr && i_addr == HREG_WDATA)
            wdat_ff <= i_wdata;
         if (go)
            is_read_ff <= i_wdata[CMD_READ_BIT];
         if (i_rd)
            o_rdata <= rd_mux;
         sda1_ff <= bus.sda;
         sda2_ff <= sda1_ff;
         qcnt_ff <= (!busy || tick) ? 12'h000 : qcnt_ff + 12'h001;
      end
   end

   // ===========================================================
   // Bit engine: four quarter-periods per bit
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_ff     <= H_STOP;
         scl_hi_ff    <= 1'b0;
         sda_hi_ff    <= 1'b1;
         q_ff         <= 2'h0;
         bit_ff       <= 4'h0;
         idx_ff       <= 2'h0;
         tx_ff        <= 9'h1FF;
         rx_ff        <= 9'h000;
         rdat_ff      <= 8'h00;
         cmd_ff       <= 1'b0;
         nack_flag_ff <= 1'b0;
         done_ff      <= 1'b0;
      end
      else
      begin
         if (stat_rd)
            done_ff <= 1'b0;
         if (go)
         begin
            state_ff     <= H_START;
            idx_ff       <= 2'h0;
            q_ff         <= 2'h0;
            cmd_ff       <= 1'b1;
            nack_flag_ff <= 1'b0;
         end
         else if (tick)
         begin
            q_ff <= q_ff + 2'h1;
            unique case (state_ff)
               H_IDLE: ;
               H_START:
                  unique case (q_ff)
                     2'h0: sda_hi_ff <= 1'b1;
                     2'h1: scl_hi_ff <= 1'b1;
                     2'h2: sda_hi_ff <= 1'b0;
                     2'h3:
                     begin
                        scl_hi_ff <= 1'b0;
                        state_ff  <= H_BIT;
                        bit_ff    <= 4'h0;
                        tx_ff     <= {next_byte, 1'b1};
                     end
                  endcase
               H_BIT:
                  unique case (q_ff)
                     2'h0: sda_hi_ff <= tx_ff[8];
                     2'h1: scl_hi_ff <= 1'b1;
                     2'h2: rx_ff <= {rx_ff[7:0], sda2_ff};
                     2'h3:
                     begin
                        scl_hi_ff <= 1'b0;
                        tx_ff     <= {tx_ff[7:0], 1'b1};
                        bit_ff    <= bit_ff + 4'h1;
                        if (bit_ff == 4'h8)
                        begin
                           bit_ff <= 4'h0;
                           idx_ff <= idx_ff + 2'h1;
                           if (is_read_ff && idx_ff == 2'h3)
                              rdat_ff <= rx_ff[8:1];
                           if (slave_nak || last_byte)
                           begin
                              nack_flag_ff <= slave_nak;
                              state_ff     <= H_STOP;
                           end
                           else if (is_read_ff && idx_ff == 2'h1)
                              state_ff <= H_START;
                           else
                              tx_ff <= {next_byte_after, 1'b1};
                        end
                     end
                  endcase
               H_STOP:
                  unique case (q_ff)
                     2'h0: sda_hi_ff <= 1'b0;
                     2'h1: scl_hi_ff <= 1'b1;
                     2'h2: sda_hi_ff <= 1'b1;
                     2'h3:
                     begin
                        state_ff <= H_IDLE;
                        cmd_ff   <= 1'b0;
                        if (cmd_ff)
                           done_ff <= 1'b1;
                     end
                  endcase
            endcase
         end
      end
   end

   // Open drain: drive low or release
   assign bus.m_scl_o  = 1'b0;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_scl_oe = ~scl_hi_ff;
   assign bus.m_sda_oe = ~sda_hi_ff;
endmodule // two_wire_master

// *** dv/two_wire_link_sva.sv ***
// Assertions on the two-wire link between the master and the regulator slave
`timescale 1ns/10ps
module two_wire_link_sva
   import regulator_pkg::*;
#(
   parameter int QTR_CYC = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_oe
);
   localparam int QLIM = 2 * QTR_CYC + 4;
   logic       scl_ff, sda_ff, first_ff, sel_ff, rd_ff;
   logic [3:0] bitn_ff;
   logic [7:0] shf_ff;
   wire        rise  = scl & ~scl_ff;
   wire        start = scl & scl_ff & sda_ff & ~sda;
   wire        stop  = scl & scl_ff & ~sda_ff & sda;
   wire        ackb  = rise & (bitn_ff == 4'h8);
   wire        match = shf_ff[7:1] == DEV_ADDR;

   // ==========
   // Bit tracking; the address byte decides who may drive SDA
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         {scl_ff, sda_ff, first_ff, sel_ff, rd_ff} <= 5'h00;
         bitn_ff <= 4'h0;
         shf_ff  <= 8'h00;
      end
      else
      begin
         scl_ff   <= scl;
         sda_ff   <= sda;
         first_ff <= start | (first_ff & ~ackb & ~stop);
         sel_ff   <= ~stop & ((ackb & first_ff) ? match : sel_ff);
         rd_ff    <= (ackb & first_ff) ? shf_ff[0] : rd_ff;
         bitn_ff  <= (start | ackb) ? 4'h0 : bitn_ff + {3'h0, rise};
         shf_ff   <= rise ? {shf_ff[6:0], sda} : shf_ff;
      end
   end

   // ==========
   // Link properties
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence
   slave_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
      else $error("slave SDA moved while SCL high");
   start_edge_a: assert property (start_s |-> ##[1:QLIM] !scl)
      else $error("SCL stayed high after start");
   start_quiet_a: assert property (start_s |-> !s_sda_oe [*8])
      else $error("slave drove SDA at start");
   stop_free_a: assert property (stop_s |=> !s_sda_oe [*8])
      else $error("slave held SDA after stop");
   addr_ack_a: assert property (ackb && first_ff |-> s_sda_oe == match)
      else $error("address acknowledge wrong");
   write_ack_a: assert property (ackb && !first_ff && sel_ff && !rd_ff |-> s_sda_oe)
      else $error("written byte not acknowledged");
   read_free_a: assert property (ackb && !first_ff && sel_ff && rd_ff |-> !s_sda_oe)
      else $error("slave drove master acknowledge slot");
   idle_quiet_a: assert property (!first_ff && !sel_ff |-> !s_sda_oe)
      else $error("unaddressed slave drove SDA");
endmodule  // two_wire_link_sva

// *** dv/tb_top.sv ***
// Self-checking bench for the regulator two-wire slave and its master
`timescale 1ns/10ps
module tb_top;
   import regulator_pkg::*;
   localparam int    QTR   = 8;
   localparam byte_t IDENT = 8'hA7;  // Arbitrary identity value
   logic       i_clk, i_resetn, wr, rd, mode_on, switch_en, discharge, load_conn;
   logic       en, supply_ok, vin_over, hot, cool, good, below;
   logic [2:0] addr;
   logic [6:0] level1, level2;
   byte_t      wdata, rdata, control;
   int         failures, n_checks;

   two_wire_if bus_if ();
   two_wire_master #(.QTR_CYC(QTR)) i_two_wire_master (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_if),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   regulator_serial_slave_status #(.IDENTITY(IDENT)) i_regulator_serial_slave_status (.i_clk(i_clk),
      .i_resetn(i_resetn), .bus(bus_if), .i_en(en), .i_supply_ok(supply_ok), .i_vin_over(vin_over),
      .i_temp_hot(hot), .i_temp_cool(cool), .i_out_above_good(good), .i_out_below_fault(below),
      .o_mode_on(mode_on), .o_switch_en(switch_en), .o_discharge(discharge), .o_load_connect(load_conn),
      .o_control(control), .o_level_primary(level1), .o_level_secondary(level2));
   two_wire_link_sva #(.QTR_CYC(QTR)) i_two_wire_link_sva (.i_clk(i_clk), .i_resetn(i_resetn),
      .scl(bus_if.scl), .sda(bus_if.sda), .s_sda_oe(bus_if.s_sda_oe));

   // ==========
   // Clock, verdict and comparisons
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk8(input byte_t g, input byte_t e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask

   // ==========
   // Command port and pin drivers
   task automatic hw(input logic [2:0] a, input byte_t d);
      @(posedge i_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_clk);
      wr    <= 1'b0;
   endtask
   task automatic hr(input logic [2:0] a, output byte_t d);
      @(posedge i_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // Pins are {en, supply, overvoltage, hot, cool, good, below}
   task automatic pins(input logic [6:0] p);
      @(posedge i_clk);
      {en, supply_ok, vin_over, hot, cool, good, below} <= p;
      repeat (8) @(posedge i_clk);
   endtask
   // One register transfer; for a read, d is the expected byte
   task automatic xfer(input logic rdn, input byte_t r, input byte_t d);
      byte_t s;
      int    n;
      n = 0;
      do
      begin
         hr(HREG_STATUS, s);
         n++;
      end
      while (s[0] !== 1'b0 && n < 99);
      hw(HREG_TARGET, r);
      hw(HREG_WDATA, d);
      hw(HREG_CMD, {6'h00, rdn, 1'b1});
      do
      begin
         hr(HREG_STATUS, s);
         n++;
      end
      while (s[2] !== 1'b1 && n < 2500);
      if (n >= 2500)
      begin
         failures++;
         end_of_test();
      end
      chk1(s[1], 1'b0);
      hr(HREG_RDATA, s);
      if (rdn)
         chk8(s, d);
   endtask

   // ==========
   // Scenarios
   task automatic t_regs();
      xfer(1'b1, OFS_CONTROL, RST_CONTROL);
      xfer(1'b1, OFS_IDENTITY, IDENT);
      xfer(1'b1, OFS_LEVEL1, {1'b0, RST_LEVEL1});
      xfer(1'b1, OFS_LEVEL2, {1'b0, RST_LEVEL2});
      xfer(1'b1, OFS_STATUS, 8'h01);
      xfer(1'b1, OFS_STATUS, 8'h00);
      xfer(1'b1, 8'h00, READ_UNMAPPED);
      xfer(1'b1, 8'h06, READ_UNMAPPED);
      xfer(1'b1, 8'hFF, READ_UNMAPPED);
      xfer(1'b0, OFS_LEVEL1, 8'hD5);
      chk8({1'b0, level1}, 8'h55);
      xfer(1'b1, OFS_LEVEL1, 8'h55);
      xfer(1'b0, OFS_IDENTITY, 8'h00);
      xfer(1'b1, OFS_IDENTITY, IDENT);
      xfer(1'b0, OFS_CONTROL, 8'h00);
      chk1(switch_en, 1'b0);
      xfer(1'b0, OFS_CONTROL, RST_CONTROL);
      chk8(control, RST_CONTROL);
      $display("test registers done");
   endtask
   task automatic t_mode();
      for (int k = 0; k < 4; k++)
      begin
         pins({k[1:0], 5'h06});
         chk1(mode_on, k == 3);
         chk1(switch_en, k == 3);
         chk1(load_conn, k == 3);
         chk1(discharge, !k[1]);
      end
      $display("test mode done");
   endtask
   task automatic t_ovp();
      pins(7'h76);
      chk1(switch_en, 1'b0);
      xfer(1'b1, OFS_STATUS, 8'h01);
      xfer(1'b1, OFS_STATUS, 8'h01);
      pins(7'h66);
      chk1(switch_en, 1'b1);
      xfer(1'b1, OFS_STATUS, 8'h01);
      xfer(1'b1, OFS_STATUS, 8'h00);
      $display("test overvoltage done");
   endtask
   task automatic t_heat();
      pins(7'h6A);
      chk1(switch_en, 1'b0);
      xfer(1'b0, OFS_LEVEL2, 8'h2A);
      chk8({1'b0, level2}, 8'h2A);
      xfer(1'b1, OFS_STATUS, 8'h02);
      pins(7'h62);
      chk1(switch_en, 1'b0);
      xfer(1'b1, OFS_STATUS, 8'h02);
      pins(7'h66);
      chk1(switch_en, 1'b1);
      xfer(1'b1, OFS_STATUS, 8'h02);
      xfer(1'b1, OFS_STATUS, 8'h00);
      $display("test thermal done");
   endtask
   task automatic t_pgood();
      pins(7'h64);
      xfer(1'b1, OFS_STATUS, 8'h00);
      pins(7'h65);
      xfer(1'b1, OFS_STATUS, 8'h01);
      pins(7'h64);
      xfer(1'b1, OFS_STATUS, 8'h01);
      pins(7'h66);
      xfer(1'b1, OFS_STATUS, 8'h01);
      xfer(1'b1, OFS_STATUS, 8'h00);
      $display("test power good done");
   endtask

   initial
   begin
      failures = 0;
      n_checks = 0;
      i_resetn = 1'b0;
      {addr, wdata, wr, rd} = '0;
      {en, supply_ok, vin_over, hot, cool, good, below} = 7'h66;
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_mode();
      t_ovp();
      t_heat();
      t_pgood();
      end_of_test();
   end
endmodule  // tb_top
